// [hdl/pbcs_top.sv]
// loop base clock select: registers, interlocks, clock switch, lock irq
// Contract
// - multiplier upper nibble, range lower nibble
// - vco runs at multiplier times crystal
// - center frequency is range times nominal
// - multiplier zero divides like one
// - range zero disables loop, blocks vco
// - range zero forces crystal as source
// - select bit picks crystal or vco
// - switch waits three edges each, output held
// - transition output divided by two
// - base clock fifty percent, twice bus
// - vco select refused while loop off
// - loop off refused while vco selected
// - power and select need separate writes
// - select reads zero when off or range zero
// - power forced on while vco selected
// - divider register locked while power on
// - manual mode: irq enable reads zero
// - manual mode: flag and lock read zero
// - oscillator enable gates crystal and loop
// - lock logic drives the interrupt output
// - flag sets on lock toggle, read clears
// - tracking bit status in auto, control manual
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module pbcs_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic crystal_ref_clock,
    input wire logic vco_clock,
    input wire logic osc_enable_in,
    input wire logic lock_detect_in,
    input wire logic tracking_status_in,
    output logic base_clock_out,
    output logic lock_irq_out,
    output logic osc_run,
    output logic loop_enable,
    output logic [3:0] feedback_divide,
    output logic [3:0] vco_range_sel,
    output logic filter_tracking_select
);
    pbcs_pkg::pbcs_state_t st_reg;
    pbcs_pkg::pbcs_state_t st_next;
    logic range_zero;
    logic vco_allowed;
    logic want_vco;
    logic xtal_rise;
    logic vco_rise;
    logic old_rise;
    logic new_rise;
    logic src_rise;
    logic lock_seen;
    logic wr_ctl;
    logic wr_bw;
    logic wr_div;

    // ----------------------------------------------------------------
    // decode and derived terms
    // ----------------------------------------------------------------
    assign range_zero = (st_reg.range_multiplier_field == 4'h0);
    assign vco_allowed = st_reg.loop_power_on & ~range_zero;
    assign want_vco = st_reg.base_clock_vco_select & vco_allowed;
    // edges seen only past the second sync stage, never the first
    assign xtal_rise = st_reg.xtal_sync[1] & ~st_reg.xtal_sync[2];
    assign vco_rise = st_reg.vco_sync[1] & ~st_reg.vco_sync[2];
    assign src_rise = st_reg.active_vco ? vco_rise : xtal_rise;
    assign old_rise = st_reg.active_vco ? vco_rise : xtal_rise;
    assign new_rise = st_reg.active_vco ? xtal_rise : vco_rise;
    // lock status is meaningless in manual mode
    assign lock_seen = st_reg.auto_mode & lock_detect_in;
    assign wr_ctl = reg_wr & (reg_addr == pbcs_pkg::LOOP_CONTROL_REG_ADDR);
    assign wr_bw = reg_wr & (reg_addr == pbcs_pkg::BANDWIDTH_REG_ADDR);
    assign wr_div = reg_wr
        & (reg_addr == pbcs_pkg::LOOP_DIVIDER_CONFIG_ADDR);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // crystal gated by the oscillator enable
        st_next.xtal_sync = {st_reg.xtal_sync[1:0],
            crystal_ref_clock & osc_enable_in};
        st_next.vco_sync = {st_reg.vco_sync[1:0],
            vco_clock & loop_enable};

        // control register: old power gates select, old select gates
        // power, so one write can never set both or clear both
        if (wr_ctl) begin
            if (st_reg.auto_mode) begin
                st_next.irq_enable =
                    reg_wdata[pbcs_pkg::CTL_IRQ_ENABLE_BIT];
            end
            if (!st_reg.base_clock_vco_select) begin
                st_next.loop_power_on =
                    reg_wdata[pbcs_pkg::CTL_POWER_BIT];
            end
            if (vco_allowed) begin
                st_next.base_clock_vco_select =
                    reg_wdata[pbcs_pkg::CTL_VCO_SELECT_BIT];
            end
        end
        // select held clear while off or range zero
        if (!vco_allowed) begin
            st_next.base_clock_vco_select = 1'b0;
        end
        if (st_reg.base_clock_vco_select) begin
            st_next.loop_power_on = 1'b1;
        end

        // bandwidth register
        if (wr_bw) begin
            st_next.auto_mode = reg_wdata[pbcs_pkg::BW_AUTO_BIT];
            if (!st_reg.auto_mode) begin
                st_next.manual_tracking =
                    reg_wdata[pbcs_pkg::BW_TRACKING_BIT];
            end
        end

        // divider register frozen while the loop runs
        if (wr_div && !st_reg.loop_power_on) begin
            st_next.multiplier_field = reg_wdata[pbcs_pkg::DIV_MULT_MSB:
                pbcs_pkg::DIV_MULT_LSB];
            st_next.range_multiplier_field =
                reg_wdata[pbcs_pkg::DIV_RANGE_MSB:
                pbcs_pkg::DIV_RANGE_LSB];
        end

        // lock change flag: read clears, a toggle in the same cycle wins
        st_next.lock_prev = lock_seen;
        if (reg_rd && reg_addr == pbcs_pkg::LOOP_CONTROL_REG_ADDR) begin
            st_next.lock_change_flag = 1'b0;
        end
        if (lock_seen != st_reg.lock_prev) begin
            st_next.lock_change_flag = 1'b1;
        end
        if (!st_reg.auto_mode) begin
            st_next.lock_change_flag = 1'b0;
        end

        // clock switch: freeze output, drain old edges, fill new ones
        case (st_reg.sw_state)
            pbcs_pkg::PBCS_RUN: begin
                if (want_vco != st_reg.active_vco) begin
                    st_next.sw_state = pbcs_pkg::PBCS_DRAIN_OLD;
                    st_next.edge_cnt = 2'h0;
                end else if (src_rise) begin
                    st_next.base_clock = ~st_reg.base_clock;
                end
            end
            pbcs_pkg::PBCS_DRAIN_OLD: begin
                // a dead old source must not hang the switch
                if (old_rise || range_zero || !osc_enable_in) begin
                    st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
                    if (st_reg.edge_cnt + 2'h1 == pbcs_pkg::SWITCH_EDGES)
                    begin
                        st_next.sw_state = pbcs_pkg::PBCS_FILL_NEW;
                        st_next.edge_cnt = 2'h0;
                    end
                end
            end
            pbcs_pkg::PBCS_FILL_NEW: begin
                if (new_rise) begin
                    st_next.edge_cnt = st_reg.edge_cnt + 2'h1;
                    if (st_reg.edge_cnt + 2'h1 == pbcs_pkg::SWITCH_EDGES)
                    begin
                        st_next.sw_state = pbcs_pkg::PBCS_RUN;
                        st_next.active_vco = ~st_reg.active_vco;
                        st_next.edge_cnt = 2'h0;
                    end
                end
            end
            default: begin
                st_next.sw_state = pbcs_pkg::PBCS_RUN;
            end
        endcase

        // read data, one cycle after the strobe
        st_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                pbcs_pkg::LOOP_CONTROL_REG_ADDR: begin
                    st_next.rdata = pbcs_pkg::CTL_RESERVED_ONES;
                    st_next.rdata[pbcs_pkg::CTL_IRQ_ENABLE_BIT] =
                        st_reg.irq_enable & st_reg.auto_mode;
                    st_next.rdata[pbcs_pkg::CTL_FLAG_BIT] =
                        st_reg.lock_change_flag & st_reg.auto_mode;
                    st_next.rdata[pbcs_pkg::CTL_POWER_BIT] =
                        st_reg.loop_power_on;
                    st_next.rdata[pbcs_pkg::CTL_VCO_SELECT_BIT] =
                        st_reg.base_clock_vco_select & vco_allowed;
                end
                pbcs_pkg::BANDWIDTH_REG_ADDR: begin
                    st_next.rdata[pbcs_pkg::BW_AUTO_BIT] = st_reg.auto_mode;
                    st_next.rdata[pbcs_pkg::BW_LOCK_BIT] = lock_seen;
                    st_next.rdata[pbcs_pkg::BW_TRACKING_BIT] =
                        filter_tracking_select;
                end
                pbcs_pkg::LOOP_DIVIDER_CONFIG_ADDR: begin
                    st_next.rdata = {st_reg.multiplier_field,
                        st_reg.range_multiplier_field};
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.loop_power_on <= pbcs_pkg::RST_POWER_ON;
            st_reg.multiplier_field <= pbcs_pkg::RST_MULTIPLIER;
            st_reg.range_multiplier_field <= pbcs_pkg::RST_RANGE;
            st_reg.sw_state <= pbcs_pkg::PBCS_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign base_clock_out = st_reg.base_clock;
    // interrupt only from the lock logic, only in auto mode
    assign lock_irq_out = st_reg.lock_change_flag & st_reg.irq_enable
        & st_reg.auto_mode;
    assign osc_run = osc_enable_in;
    assign loop_enable = osc_enable_in & vco_allowed;
    // divider value sets vco = n times crystal; zero acts as one
    assign feedback_divide = (st_reg.multiplier_field == pbcs_pkg::MULT_ZERO)
        ? pbcs_pkg::MULT_ONE : st_reg.multiplier_field;
    // analog centre = range times NOMINAL_RANGE_MHZ
    assign vco_range_sel = st_reg.range_multiplier_field;
    assign filter_tracking_select = st_reg.auto_mode ? tracking_status_in
        : st_reg.manual_tracking;
endmodule : pbcs_top

// [inc/pbcs_pkg.sv]
// constants and types for the loop base clock select block
package pbcs_pkg;
    // ----------------------------------------------------------------
    // register map (word index on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [1:0] LOOP_CONTROL_REG_ADDR = 2'h0;
    localparam logic [1:0] BANDWIDTH_REG_ADDR = 2'h1;
    localparam logic [1:0] LOOP_DIVIDER_CONFIG_ADDR = 2'h2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTL_IRQ_ENABLE_BIT = 7;
    localparam int CTL_FLAG_BIT = 6;
    localparam int CTL_POWER_BIT = 5;
    localparam int CTL_VCO_SELECT_BIT = 4;
    localparam logic [7:0] CTL_RESERVED_ONES = 8'h0f;
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_TRACKING_BIT = 5;
    localparam int DIV_MULT_MSB = 7;
    localparam int DIV_MULT_LSB = 4;
    localparam int DIV_RANGE_MSB = 3;
    localparam int DIV_RANGE_LSB = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_POWER_ON = 1'b1;
    localparam logic [3:0] RST_MULTIPLIER = 4'h6;
    localparam logic [3:0] RST_RANGE = 4'h6;

    // ----------------------------------------------------------------
    // clock switching, multiplier and range constants
    // ----------------------------------------------------------------
    localparam logic [1:0] SWITCH_EDGES = 2'h3;
    localparam logic [3:0] MULT_ZERO = 4'h0;
    localparam logic [3:0] MULT_ONE = 4'h1;
    localparam real NOMINAL_RANGE_MHZ = 4.9152;

    typedef enum logic [1:0] {
        PBCS_RUN = 2'b00,
        PBCS_DRAIN_OLD = 2'b01,
        PBCS_FILL_NEW = 2'b10
    } pbcs_switch_t;

    typedef struct packed {
        logic irq_enable;
        logic lock_change_flag;
        logic loop_power_on;
        logic base_clock_vco_select;
        logic auto_mode;
        logic manual_tracking;
        logic lock_prev;
        logic [3:0] multiplier_field;
        logic [3:0] range_multiplier_field;
        logic [2:0] xtal_sync;
        logic [2:0] vco_sync;
        pbcs_switch_t sw_state;
        logic [1:0] edge_cnt;
        logic active_vco;
        logic base_clock;
        logic [7:0] rdata;
    } pbcs_state_t;
endpackage : pbcs_pkg

// [testbench/pbcs_props.sv]
// checker: port level assertions for the loop base clock select block
`timescale 1ns/100ps
module pbcs_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic osc_enable_in,
    input wire logic lock_detect_in,
    input wire logic base_clock_out,
    input wire logic lock_irq_out,
    input wire logic osc_run,
    input wire logic loop_enable,
    input wire logic [3:0] feedback_divide,
    input wire logic [3:0] vco_range_sel
);
    // ------------------------------------------------------------
    // assertions, all in the core clock domain
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_osc_follow: assert property (osc_run == osc_enable_in)
        else $error("osc run differs from enable");
    chk_loop_gate: assert property (loop_enable |->
        osc_enable_in && vco_range_sel != 4'h0)
        else $error("loop enabled while gated");
    chk_mult_nonzero: assert property (feedback_divide != 4'h0)
        else $error("feedback divide is zero");
    chk_div_locked: assert property (loop_enable && reg_wr &&
        reg_addr == 2'h2 |=> $stable({feedback_divide, vco_range_sel}))
        else $error("divider changed while loop on");
    chk_sel_range: assert property (reg_rd && reg_addr == 2'h0 &&
        vco_range_sel == 4'h0 |=> reg_rdata[4:0] == 5'h0f)
        else $error("select reads one with range zero");
    chk_sel_power: assert property (reg_rd && reg_addr == 2'h0 ##1
        reg_rdata[4] |-> reg_rdata[5])
        else $error("select set without power");
    chk_manual_lock: assert property (reg_rd && reg_addr == 2'h1 ##1
        !reg_rdata[7] |-> reg_rdata[6] == 1'b0)
        else $error("lock reads one in manual mode");
    // sources in use are never faster than three core cycles per half
    chk_no_runt: assert property ($changed(base_clock_out) |=>
        $stable(base_clock_out)[*2])
        else $error("base clock pulse too short");
    chk_flag_clear: assert property ($stable(lock_detect_in)[*3] ##0
        (reg_rd && reg_addr == 2'h0) ##1 $stable(lock_detect_in)[*2]
        |=> !lock_irq_out)
        else $error("interrupt stays after control read");
endmodule : pbcs_props

bind pbcs_top pbcs_props i_pbcs_props (.core_clk(core_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_enable_in(osc_enable_in),
    .lock_detect_in(lock_detect_in), .base_clock_out(base_clock_out),
    .lock_irq_out(lock_irq_out), .osc_run(osc_run),
    .loop_enable(loop_enable), .feedback_divide(feedback_divide),
    .vco_range_sel(vco_range_sel));

// [testbench/pbcs_sim_model.sv]
// system side model: consumes the base clock and reports its period
`timescale 1ns/100ps
module pbcs_sim_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic base_clock_out,
    output logic [7:0] period
);
    logic [7:0] cnt;
    logic prev;
    // ------------------------------------------------------------
    // rise to rise period in core cycles
    // ------------------------------------------------------------
    // rise to rise, so a skewed duty cycle cannot hide a wrong rate
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt <= 8'h00;
            prev <= 1'b0;
            period <= 8'h00;
        end else begin
            prev <= base_clock_out;
            cnt <= cnt + 8'h01;
            if (base_clock_out && !prev) begin
                period <= cnt + 8'h01;
                cnt <= 8'h00;
            end
        end
    end
endmodule : pbcs_sim_model

// [testbench/pbcs_top_tb.sv]
// self-checking bench for the loop base clock select block
`timescale 1ns/100ps
module pbcs_top_tb;
    logic core_clk, reset, reg_wr, reg_rd, lock_detect_in, osc_enable_in;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, period, dv;
    logic crystal_ref_clock, vco_clock, tracking_status_in, osc_run;
    logic base_clock_out, lock_irq_out, loop_enable, filter_tracking_select;
    logic [3:0] feedback_divide, vco_range_sel;
    logic [2:0] xcnt, vcnt;
    int err_total, compares, seed, i;

    pbcs_top i_pbcs_top (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crystal_ref_clock(crystal_ref_clock), .vco_clock(vco_clock),
        .osc_enable_in(osc_enable_in), .lock_detect_in(lock_detect_in),
        .tracking_status_in(tracking_status_in),
        .base_clock_out(base_clock_out), .lock_irq_out(lock_irq_out),
        .osc_run(osc_run), .loop_enable(loop_enable),
        .feedback_divide(feedback_divide), .vco_range_sel(vco_range_sel),
        .filter_tracking_select(filter_tracking_select));
    pbcs_sim_model i_pbcs_sim_model (.core_clk(core_clk), .reset(reset),
        .base_clock_out(base_clock_out), .period(period));

    // ------------------------------------------------------------
    // clocks: crystal period 8 cycles, vco period 6 cycles
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // sources kept well under half the core rate for the synchronisers
    always @(posedge core_clk) begin
        xcnt <= (xcnt == 3'h3) ? 3'h0 : xcnt + 3'h1;
        vcnt <= (vcnt == 3'h2) ? 3'h0 : vcnt + 3'h1;
        if (xcnt == 3'h3) crystal_ref_clock <= ~crystal_ref_clock;
        if (vcnt == 3'h2) vco_clock <= ~vco_clock;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rdchk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdchk
    task per(input logic [7:0] exp);
        repeat (80) @(posedge core_clk);
        chk(period, exp);
    endtask : per
    function automatic logic [7:0] ectl(logic ie, logic f, logic p, logic s);
        return {ie, f, p, s, 4'hf};
    endfunction : ectl
    function automatic logic [7:0] ediv(logic [3:0] m);
        return {4'h0, (m == 4'h0) ? 4'h1 : m};
    endfunction : ediv
    task finish_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #1000000 err_total++;
        finish_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, lock_detect_in} = '0;
        {crystal_ref_clock, vco_clock, xcnt, vcnt} = '0;
        osc_enable_in = 1'b1;
        seed = 32'h9c515361;
        tracking_status_in = 1'b0;
        reset = 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rdchk(2'h0, ectl(0, 0, 1, 0));
        rdchk(2'h2, 8'h66);
        rdchk(2'h3, 8'h00);
        wr(2'h2, 8'($random(seed)));
        rdchk(2'h2, 8'h66);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h10);
        rdchk(2'h0, ectl(0, 0, 0, 0));
        for (i = 0; i < 6; i++) begin
            dv = 8'($random(seed));
            if (i == 0) dv[7:4] = 4'h0;
            wr(2'h2, dv);
            rdchk(2'h2, dv);
            chk({4'h0, feedback_divide}, ediv(dv[7:4]));
            chk({4'h0, vco_range_sel}, {4'h0, dv[3:0]});
        end
        wr(2'h2, 8'h80);
        wr(2'h0, 8'h20);
        wr(2'h0, 8'h30);
        rdchk(2'h0, ectl(0, 0, 1, 0));
        chk({7'h0, loop_enable}, 8'h00);
        per(8'h10);
        wr(2'h0, 8'h00);
        wr(2'h2, 8'h87);
        wr(2'h0, 8'h30);
        rdchk(2'h0, ectl(0, 0, 1, 0));
        wr(2'h0, 8'h30);
        rdchk(2'h0, ectl(0, 0, 1, 1));
        per(8'h0c);
        wr(2'h0, 8'h00);
        // deselect lands, power off is refused while selected
        rdchk(2'h0, ectl(0, 0, 1, 0));
        osc_enable_in <= 1'b0;
        @(posedge core_clk);
        #1 chk({6'h0, osc_run, loop_enable}, 8'h00);
        osc_enable_in <= 1'b1;
        wr(2'h0, 8'ha0);
        rdchk(2'h0, ectl(0, 0, 1, 0));
        per(8'h10);
        wr(2'h1, 8'h20);
        rdchk(2'h1, 8'h20);
        wr(2'h1, 8'h80);
        tracking_status_in <= 1'($random(seed));
        @(posedge core_clk);
        #1 dv = {7'h0, tracking_status_in};
        chk({7'h0, filter_tracking_select}, dv);
        wr(2'h0, 8'ha0);
        lock_detect_in <= 1'b1;
        // look a little after the edge, once the flag has settled
        for (i = 0; i < 20 && lock_irq_out !== 1'b1; i++)
            @(posedge core_clk) #1;
        chk({7'h0, lock_irq_out}, 8'h01);
        repeat (4) @(posedge core_clk);
        rdchk(2'h0, ectl(1, 1, 1, 0));
        repeat (3) @(posedge core_clk);
        chk({7'h0, lock_irq_out}, 8'h00);
        // back to manual with lock still high: lock, flag, enable read 0
        wr(2'h1, 8'h00);
        rdchk(2'h1, 8'h00);
        rdchk(2'h0, ectl(0, 0, 1, 0));
        chk({7'h0, lock_irq_out}, 8'h00);
        finish_test;
    end
endmodule : pbcs_top_tb
